// >>> hdl/four_port_parallel_io.sv
// Functional notes
// - 31 lines: three 8-bit ports, one 7-bit
// - direction 1 drives latch, 0 is input
// - reset clears directions, latches kept
// - first port data 0, direction 4
// - second port data 1, direction 5
// - third port data 2, direction 6
// - fourth port data 3, direction 7
// - second port interrupt option per pin
// - interrupt option enables pullup on inputs
// - enabled pins share external pin sensitivity
// - fourth port pins shareable with serial units
// - reset disables serial drivers, directions cleared
// - stop mode freezes every line
// - wait mode keeps lines and registers
// - sensitivity chosen by option register bit
//
// Design decision made here: the AXI4-Lite slave port.
module four_port_parallel_io
    import parallel_io_pkg::*;
#(
    parameter logic [7:0] SECOND_IRQ_OPTION = 8'h00
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] first_pin_in,
    input wire logic [7:0] second_pin_in,
    input wire logic [7:0] third_pin_in,
    input wire logic [6:0] fourth_pin_in,
    output port_pins_t first_pins,
    output port_pins_t second_pins,
    output port_pins_t third_pins,
    output port_pins_t fourth_pins,
    output logic [7:0] second_pullup,
    input wire logic [6:0] serial_take,
    input wire logic [6:0] serial_drive,
    input wire logic [6:0] serial_enable,
    input wire logic ext_irq_n,
    output logic irq_request,
    input wire logic stop_mode,
    input wire logic wait_mode
);
    logic [7:0] latch [NUM_PORTS];
    logic [7:0] direction [NUM_PORTS];
    logic level_sense;
    logic [7:0] pin_in [NUM_PORTS];
    wr_state_t wr_state;
    logic [31:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic [7:0] serial_active;
    logic [7:0] freeze_drive [NUM_PORTS];
    logic [7:0] freeze_enable [NUM_PORTS];
    logic [7:0] next_drive [NUM_PORTS];
    logic [7:0] next_enable [NUM_PORTS];
    logic [7:0] line_level [NUM_PORTS];
    logic [7:0] prev_line;
    logic prev_ext;
    logic irq_latch;
    logic [7:0] armed_low;
    logic frozen;

    assign frozen = stop_mode || wait_mode;
    assign pin_in[0] = first_pin_in;
    assign pin_in[1] = second_pin_in;
    assign pin_in[2] = third_pin_in;
    assign pin_in[3] = {1'b0, fourth_pin_in};
    // serial takeover only after reset has released its drivers
    assign serial_active = aresetn ? {1'b0, serial_take} : 8'h00;

    // address decode: each register is one aligned word, byte address is four times its index
    function automatic logic [3:0] decode(input logic [31:0] addr);
        logic [3:0] sel;
        sel = 4'h0;
        if (addr[31:5] == 27'h0 && addr[1:0] == 2'h0) begin
            sel = {1'b1, addr[4:2]};
        end
        return sel;
    endfunction

    // write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= ZERO_WORD;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_state == WR_RESP && s_axi_bready) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= ZERO_WORD;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_state == WR_RESP && s_axi_bready) begin
            w_held <= 1'b0;
        end
    end

    assign s_axi_awready = (wr_state == WR_IDLE) && !aw_held;
    assign s_axi_wready = (wr_state == WR_IDLE) && !w_held;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state <= WR_IDLE;
        end else begin
            case (wr_state)
                WR_IDLE: begin
                    if (aw_held && w_held) begin
                        wr_state <= WR_HAVE;
                    end
                end
                WR_HAVE: begin
                    wr_state <= WR_RESP;
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state <= WR_IDLE;
                    end
                end
                default: begin
                    wr_state <= WR_IDLE;
                end
            endcase
        end
    end

    logic wr_hit;
    logic wr_option;
    logic [3:0] wr_sel;
    assign wr_sel = decode(aw_addr);
    assign wr_option = (aw_addr[31:WORD_SHIFT] == {18'h0, OPTION_INDEX});
    assign wr_hit = wr_sel[3] || wr_option;
    assign s_axi_bvalid = (wr_state == WR_RESP);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_state == WR_HAVE) begin
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // latches never reset by aresetn; software must load them first
    logic [7:0] wr_byte;
    assign wr_byte = w_data[7:0];
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
            localparam logic [7:0] WMASK = (gp == NUM_PORTS - 1) ? FOURTH_MASK : 8'hff;
            logic init_done = 1'b0;
            always_ff @(posedge aclk) begin
                // one-time load so simulation does not start at unknown
                if (!init_done) begin
                    latch[gp] <= LATCH_INIT;
                end else if (wr_state == WR_HAVE && wr_sel == {2'b10, 2'(gp)} && w_strb[0] && !wait_mode) begin
                    latch[gp] <= wr_byte & WMASK;
                end
            end
            always_ff @(posedge aclk) begin
                init_done <= 1'b1;
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    direction[gp] <= DIRECTION_RESET;
                end else if (wr_state == WR_HAVE && wr_sel == {2'b11, 2'(gp)} && w_strb[0] && !wait_mode) begin
                    direction[gp] <= wr_byte & WMASK;
                end
            end
            always_comb begin
                next_enable[gp] = direction[gp];
                next_drive[gp] = latch[gp] & direction[gp];
                if (gp == NUM_PORTS - 1) begin
                    next_enable[gp] = (direction[gp] & ~serial_active) | (serial_active & {1'b0, serial_enable});
                    next_drive[gp] = (next_drive[gp] & ~serial_active)
                        | (serial_active & {1'b0, serial_drive});
                end
            end
            // stop or wait hold the pad drivers where they stood
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    freeze_drive[gp] <= 8'h00;
                    freeze_enable[gp] <= 8'h00;
                end else if (!frozen) begin
                    freeze_drive[gp] <= next_drive[gp];
                    freeze_enable[gp] <= next_enable[gp];
                end
            end
            assign line_level[gp] = (direction[gp] & latch[gp]) | (~direction[gp] & pin_in[gp]);
        end
    endgenerate

    assign first_pins = '{level: line_level[0], drive: freeze_drive[0], enable: freeze_enable[0]};
    assign second_pins = '{level: line_level[1], drive: freeze_drive[1], enable: freeze_enable[1]};
    assign third_pins = '{level: line_level[2], drive: freeze_drive[2], enable: freeze_enable[2]};
    assign fourth_pins = '{level: line_level[3], drive: freeze_drive[3], enable: freeze_enable[3]};
    assign second_pullup = SECOND_IRQ_OPTION & ~freeze_enable[1];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_sense <= OPTION_SENS_RESET;
        end else if (wr_state == WR_HAVE && wr_option && w_strb[0] && !wait_mode) begin
            level_sense <= w_data[OPTION_SENS_BIT];
        end
    end

    // read channel, one cycle to answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= ZERO_WORD;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= ZERO_WORD;
            if (decode(s_axi_araddr) == 4'h0) begin
                if (s_axi_araddr[31:WORD_SHIFT] == {18'h0, OPTION_INDEX}) begin
                    s_axi_rdata[OPTION_SENS_BIT] <= level_sense;
                end else begin
                    s_axi_rresp <= RESP_SLVERR;
                end
            end else if (s_axi_araddr[4]) begin
                s_axi_rdata[7:0] <= direction[s_axi_araddr[3:2]];
            end else begin
                s_axi_rdata[7:0] <= line_level[s_axi_araddr[3:2]];
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;

    // second port interrupt, merged with the external pin
    logic [7:0] sec_line;
    assign sec_line = line_level[1] & SECOND_IRQ_OPTION | ~SECOND_IRQ_OPTION;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_line <= 8'hff;
            prev_ext <= 1'b1;
        end else begin
            prev_line <= sec_line;
            prev_ext <= ext_irq_n;
        end
    end
    assign armed_low = ~sec_line;
    logic fall_event;
    logic low_event;
    assign fall_event = (|(prev_line & ~sec_line)) || (prev_ext && !ext_irq_n);
    assign low_event = level_sense && ((|armed_low) || !ext_irq_n);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_latch <= 1'b0;
        end else begin
            irq_latch <= fall_event || low_event;
        end
    end
    assign irq_request = irq_latch;

    chk_direction_reset: assert property (@(posedge aclk) !aresetn |=> direction[0] == 8'h00 && direction[3] == 8'h00)
        else $error("direction not cleared by reset");
    chk_fourth_top_bit: assert property (@(posedge aclk) disable iff (!aresetn) latch[3][7] == 1'b0)
        else $error("fourth port bit seven set");
    chk_enable_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        !frozen && !$past(frozen) |-> first_pins.enable == $past(direction[0]))
        else $error("first port enable not following direction");
    chk_stop_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_mode && $past(stop_mode) |-> $stable(third_pins.drive) && $stable(third_pins.enable))
        else $error("lines moved in stop");
    chk_wait_regs: assert property (@(posedge aclk) disable iff (!aresetn)
        wait_mode |=> direction[1] == $past(direction[1]))
        else $error("register changed in wait");
    chk_pullup_input: assert property (@(posedge aclk) disable iff (!aresetn)
        second_pullup == (SECOND_IRQ_OPTION & ~second_pins.enable))
        else $error("pullup wrong");
    chk_read_level: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h0 |=> s_axi_rdata[7:0] == $past(line_level[0]))
        else $error("port read wrong");
    chk_fall_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(ext_irq_n) && !ext_irq_n |=> irq_request)
        else $error("falling edge missed");
    chk_serial_off_reset: assert property (@(posedge aclk) !aresetn |=> fourth_pins.enable == 8'h00)
        else $error("serial driver during reset");
    chk_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    chk_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_arready_busy: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    chk_write_refused: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_state != WR_IDLE |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    chk_write_okay: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_state == WR_HAVE && wr_hit |=> s_axi_bresp == RESP_OKAY)
        else $error("mapped write not okay");
    chk_write_err: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_state == WR_HAVE && !wr_hit |=> s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write not refused");
    chk_first_dir: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == {18'h0, FIRST_PORT_DIRECTION, 2'h0}
        |=> s_axi_rdata[7:0] == $past(direction[0])) else $error("first direction read wrong");
    chk_second_read: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == {18'h0, SECOND_PORT_DATA, 2'h0}
        |=> s_axi_rdata[7:0] == $past(line_level[1])) else $error("second data read wrong");
    chk_third_dir: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == {18'h0, THIRD_PORT_DIRECTION, 2'h0}
        |=> s_axi_rdata[7:0] == $past(direction[2])) else $error("third direction read wrong");
    chk_fourth_read: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == {18'h0, FOURTH_PORT_DATA, 2'h0}
        |=> s_axi_rdata[7:0] == $past(line_level[3])) else $error("fourth data read wrong");
    chk_level_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        level_sense && !ext_irq_n |=> irq_request)
        else $error("low level missed");
    // a write finishing in the reset cycle itself is not covered here
    chk_latch_kept: assert property (@(posedge aclk)
        !aresetn && wr_state != WR_HAVE && g_port[0].init_done |=> latch[0] == $past(latch[0]))
        else $error("latch changed by reset");
    chk_fourth_dir_top: assert property (@(posedge aclk) disable iff (!aresetn)
        direction[3][7] == 1'b0)
        else $error("fourth direction bit seven set");
    chk_wait_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        wait_mode |=> latch[0] == $past(latch[0]))
        else $error("latch changed in wait");
    chk_wait_lines: assert property (@(posedge aclk) disable iff (!aresetn)
        wait_mode && $past(wait_mode) |-> $stable(second_pins.enable) && $stable(second_pins.drive))
        else $error("lines moved in wait");
    chk_out_level: assert property (@(posedge aclk) disable iff (!aresetn)
        (third_pins.level & direction[2]) == (latch[2] & direction[2]))
        else $error("output bits not read from latch");
    chk_in_level: assert property (@(posedge aclk) disable iff (!aresetn)
        (first_pins.level & ~direction[0]) == (first_pin_in & ~direction[0]))
        else $error("input bits not read from pin");
    chk_drive_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        !frozen && !$past(frozen) |-> third_pins.drive == $past(latch[2] & direction[2]))
        else $error("third port drive not following latch");
    chk_serial_enable: assert property (@(posedge aclk) disable iff (!aresetn)
        serial_take[0] && !frozen |=> fourth_pins.enable[0] == $past(serial_enable[0]))
        else $error("serial unit not driving its pin");
    cov_write: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
    cov_read: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
    cov_irq: cover property (@(posedge aclk) irq_request);
    cov_stop: cover property (@(posedge aclk) stop_mode ##1 !stop_mode);
endmodule // four_port_parallel_io

// >>> hdl/parallel_io_pkg.sv
package parallel_io_pkg;
    localparam int NUM_PORTS = 4;
    localparam int PORT_WIDTH = 8;
    localparam int FOURTH_WIDTH = 7;
    localparam int TOTAL_LINES = 31;
    localparam logic [7:0] FOURTH_MASK = 8'h7f;
    // word indices of the eight port registers and the option register, one aligned word each; byte offset is four times the index
    localparam logic [11:0] FIRST_PORT_DATA = 12'h000;
    localparam logic [11:0] SECOND_PORT_DATA = 12'h001;
    localparam logic [11:0] THIRD_PORT_DATA = 12'h002;
    localparam logic [11:0] FOURTH_PORT_DATA = 12'h003;
    localparam logic [11:0] FIRST_PORT_DIRECTION = 12'h004;
    localparam logic [11:0] SECOND_PORT_DIRECTION = 12'h005;
    localparam logic [11:0] THIRD_PORT_DIRECTION = 12'h006;
    localparam logic [11:0] FOURTH_PORT_DIRECTION = 12'h007;
    localparam logic [11:0] OPTION_INDEX = 12'h3df;
    localparam int WORD_SHIFT = 2;
    localparam int REG_INDEX_COUNT = 8;
    localparam int OPTION_SENS_BIT = 1;
    localparam logic [7:0] DIRECTION_RESET = 8'h00;
    localparam logic [7:0] LATCH_INIT = 8'h00;
    localparam logic OPTION_SENS_RESET = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    typedef struct packed {
        logic [7:0] level;
        logic [7:0] drive;
        logic [7:0] enable;
    } port_pins_t;

    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_HAVE = 3'b010,
        WR_RESP = 3'b100
    } wr_state_t;
endpackage

// >>> tb/board_model.sv
module board_model
    import parallel_io_pkg::*;
(
    input port_pins_t first_pins,
    input port_pins_t second_pins,
    input port_pins_t third_pins,
    input port_pins_t fourth_pins,
    input wire logic [31:0] level,
    output logic [7:0] first_pin_in,
    output logic [7:0] second_pin_in,
    output logic [7:0] third_pin_in,
    output logic [6:0] fourth_pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] fourth_full;
    // board drives every line the port leaves as input; driven lines read back
    function automatic logic [7:0] res(port_pins_t p, logic [7:0] b);
        return (p.enable & p.drive) | (~p.enable & b);
    endfunction
    assign first_pin_in = res(first_pins, level[7:0]);
    assign second_pin_in = res(second_pins, level[15:8]);
    assign third_pin_in = res(third_pins, level[23:16]);
    assign fourth_full = res(fourth_pins, level[31:24]);
    assign fourth_pin_in = fourth_full[6:0];
endmodule // board_model

// >>> tb/tb_top.sv
module tb_top
    import parallel_io_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [7:0] first_pin_in, second_pin_in, third_pin_in, second_pullup;
    logic [6:0] fourth_pin_in, serial_take = 7'h00, serial_drive = 7'h2b, serial_enable = 7'h7f;
    port_pins_t first_pins, second_pins, third_pins, fourth_pins, pp;
    logic ext_irq_n = 1'h1, irq_request, stop_mode = 1'h0, wait_mode = 1'h0;
    logic [31:0] level = 32'h5533ff0f;
    int errors = 0, n_checks = 0;
    typedef struct {int p; logic [7:0] latch; logic [7:0] dir; logic [7:0] rdv;} row_t;
    row_t rows[6] = '{'{0, 8'ha5, 8'hff, 8'ha5}, '{0, 8'ha5, 8'h00, 8'h0f}, '{1, 8'h5a, 8'hf0, 8'h5f},
        '{2, 8'hff, 8'h0f, 8'h3f}, '{3, 8'hff, 8'hff, 8'h7f}, '{3, 8'h00, 8'h70, 8'h05}};

    four_port_parallel_io #(.SECOND_IRQ_OPTION(8'h0f)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .first_pin_in, .second_pin_in, .third_pin_in, .fourth_pin_in, .first_pins, .second_pins,
        .third_pins, .fourth_pins, .second_pullup, .serial_take, .serial_drive, .serial_enable, .ext_irq_n,
        .irq_request, .stop_mode, .wait_mode);
    board_model board (.first_pins, .second_pins, .third_pins, .fourth_pins, .level, .first_pin_in,
        .second_pin_in, .third_pin_in, .fourth_pin_in);

    initial forever #20 aclk = ~aclk;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic give_up();
        errors++;
        print_verdict();
    endtask
    // awready/wready are combinational, so sample them 1 ns after the edge
    task automatic bus_write(input logic [11:0] idx, input logic [7:0] d);
        logic aw, w, b;
        int n;
        @(posedge aclk);
        s_axi_awaddr <= {18'h0, idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        b = 1'h0;
        for (n = 0; n < 40 && !b; n++) begin
            #1;
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid === 1'h1;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
        if (!b) give_up();
        check("bresp", 32'(RESP_OKAY), 32'(resp));
    endtask
    task automatic bus_read(input logic [11:0] idx);
        logic a, r;
        int n;
        @(posedge aclk);
        s_axi_araddr <= {18'h0, idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        r = 1'h0;
        for (n = 0; n < 40 && !r; n++) begin
            #1;
            a = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid === 1'h1;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (a) s_axi_arvalid <= 1'h0;
        end
        s_axi_rready <= 1'h0;
        if (!r) give_up();
    endtask
    task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
        bus_read(idx);
        check("rdata", exp, rd);
        check("rresp", 32'(RESP_OKAY), 32'(resp));
    endtask
    task automatic wait_irq(input logic v);
        int n;
        for (n = 0; n < 8 && irq_request !== v; n++) @(negedge aclk);
        check("irq", 32'(v), 32'(irq_request));
        if (n == 8) give_up();
    endtask

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        for (int p = 0; p < 4; p++) rd_chk(FIRST_PORT_DIRECTION + 12'(p), 32'h0);
        foreach (rows[i]) begin
            bus_write(FIRST_PORT_DATA + 12'(rows[i].p), rows[i].latch);
            bus_write(FIRST_PORT_DIRECTION + 12'(rows[i].p), rows[i].dir);
            rd_chk(FIRST_PORT_DATA + 12'(rows[i].p), 32'(rows[i].rdv));
            @(negedge aclk);
            pp = rows[i].p == 0 ? first_pins : rows[i].p == 1 ? second_pins : rows[i].p == 2 ? third_pins : fourth_pins;
            check("enable", 32'(rows[i].dir & (rows[i].p == 3 ? FOURTH_MASK : 8'hff)), 32'(pp.enable));
            check("drive", 32'(rows[i].dir & rows[i].latch & 8'h7f), 32'(pp.drive & pp.enable & 8'h7f));
        end
        check("pullup", 32'h0f, 32'(second_pullup));
        bus_read(12'h008);
        check("slverr", 32'(RESP_SLVERR), 32'(resp));
        check("unmapped", 32'h0, rd);
        // stop freezes the lines even though the register write lands
        bus_write(FIRST_PORT_DIRECTION, 8'hff);
        @(posedge aclk) stop_mode <= 1'h1;
        bus_write(FIRST_PORT_DIRECTION, 8'h00);
        @(negedge aclk);
        check("stop enable", 32'hff, 32'(first_pins.enable));
        @(posedge aclk) stop_mode <= 1'h0;
        repeat (3) @(negedge aclk);
        check("enable", 32'h00, 32'(first_pins.enable));
        @(posedge aclk) wait_mode <= 1'h1;
        bus_write(FIRST_PORT_DIRECTION, 8'hff);
        rd_chk(FIRST_PORT_DIRECTION, 32'h0);
        check("wait enable", 32'h00, 32'(first_pins.enable));
        @(posedge aclk) wait_mode <= 1'h0;
        bus_write(FIRST_PORT_DIRECTION, 8'hff);
        @(posedge aclk) serial_take <= 7'h7f;
        repeat (2) @(negedge aclk);
        check("serial", 32'h7f2b, {16'h0, fourth_pins.enable, fourth_pins.drive});
        @(posedge aclk) aresetn <= 1'h0;
        repeat (2) @(negedge aclk);
        check("reset enable", 32'h0, 32'(fourth_pins.enable | first_pins.enable));
        @(posedge aclk) aresetn <= 1'h1;
        rd_chk(FIRST_PORT_DIRECTION, 32'h0);
        serial_take <= 7'h00;
        bus_write(FIRST_PORT_DIRECTION, 8'hff);
        rd_chk(FIRST_PORT_DATA, 32'ha5);
        bus_write(SECOND_PORT_DATA, 8'hff);
        bus_write(SECOND_PORT_DIRECTION, 8'h00);
        wait_irq(1'h0);
        @(posedge aclk) level[12] <= 1'h0;
        repeat (4) @(negedge aclk);
        wait_irq(1'h0);
        @(posedge aclk) level[8] <= 1'h0;
        wait_irq(1'h1);
        wait_irq(1'h0);
        bus_write(OPTION_INDEX, 8'h02);
        wait_irq(1'h1);
        @(posedge aclk) level[8] <= 1'h1;
        wait_irq(1'h0);
        @(posedge aclk) ext_irq_n <= 1'h0;
        wait_irq(1'h1);
        @(posedge aclk) ext_irq_n <= 1'h1;
        wait_irq(1'h0);
        print_verdict();
    end
endmodule // tb_top
